// >>> hw/sbcw_mode_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Top three frame bits select the register
// - Bit 12 set means read back only
// - Select 0: window in Normal, timeout Standby
// - Select 1: timeout in Normal, off Standby
// - Period code picks 8 to 4096 ms
// - Bit 7 reads disable pin level
// - Writing bit 7 high requests soft reset
// - Bit 6 reports main supply undervoltage
// - Bit 5 reports transceiver supply undervoltage
// - Bit 4 reports wake input one level
// - Bit 3 reports wake input two level
// - Mode codes: standby, sleep, normal supply off
// - Mode code 11: normal, transceiver supply on
module sbcw_mode_regs (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiDataIn,
	output logic spiDataOut,
	output logic spiDataOutEn,
	input wire logic watchdogDisablePin,
	input wire logic mainSupplyUndervolt,
	input wire logic xcvrSupplyUndervolt,
	input wire logic wakeInputOneLevel,
	input wire logic wakeInputTwoLevel,
	output logic [1:0] operatingMode,
	output logic xcvrSupplyEnable,
	output logic watchdogModeSelect,
	output logic [2:0] watchdogPeriodCode,
	output logic [12:0] watchdogPeriodMs,
	output sbcw_pkg::sbcw_wdmode_e watchdogMode,
	output logic softResetReq
);
	logic frameDone;
	logic [15:0] rxWord;
	logic [2:0] rxAddr;
	logic [12:0] txData;
	logic writeStrobe;
	logic [2:0] frameAddr;
	logic [2:0] framePeriod;
	logic [1:0] frameMode;

	logic wdSel_reg, wdSel_next;
	logic [2:0] period_reg, period_next;
	logic [1:0] mode_reg, mode_next;
	logic softRst_reg, softRst_next;
	logic xcvrEn_reg, xcvrEn_next;

	////////////////////////////////////////////////////////////////
	// Serial front end
	sbcw_spi_shift shifter (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.spiClk(spiClk),
		.spiCsN(spiCsN),
		.spiDataIn(spiDataIn),
		.spiDataOut(spiDataOut),
		.spiDataOutEn(spiDataOutEn),
		.txData(txData),
		.rxAddr(rxAddr),
		.frameDone(frameDone),
		.rxWord(rxWord)
	);

	////////////////////////////////////////////////////////////////
	// Fields of the completed frame
	assign frameAddr = rxWord[sbcw_pkg::ADDR_MSB:sbcw_pkg::ADDR_LSB];
	assign framePeriod = rxWord[sbcw_pkg::PERIOD_MSB:sbcw_pkg::PERIOD_LSB];
	assign frameMode = rxWord[sbcw_pkg::MODE_MSB:sbcw_pkg::MODE_LSB];
	// A set access flag turns the frame into a pure read
	assign writeStrobe = frameDone && !rxWord[sbcw_pkg::ACCESS_BIT];

	////////////////////////////////////////////////////////////////
	// Readback of bits 12:0 for the addressed register; status is live
	always_comb begin
		txData = 13'h0000;
		unique case (rxAddr)
			sbcw_pkg::ADDR_WD_STATUS: begin
				txData[sbcw_pkg::WMS_BIT] = wdSel_reg;
				txData[sbcw_pkg::PERIOD_MSB:sbcw_pkg::PERIOD_LSB] = period_reg;
				txData[sbcw_pkg::WOFF_BIT] = watchdogDisablePin;
				txData[sbcw_pkg::MAINUV_BIT] = mainSupplyUndervolt;
				txData[sbcw_pkg::XCVRUV_BIT] = xcvrSupplyUndervolt;
				txData[sbcw_pkg::LOCAL_WAKE_INPUT_ONE_BIT] = wakeInputOneLevel;
				txData[sbcw_pkg::LOCAL_WAKE_INPUT_TWO_BIT] = wakeInputTwoLevel;
				// Reserved 2:0 stay at their zero default
			end
			sbcw_pkg::ADDR_MODE_CTRL: begin
				txData[sbcw_pkg::MODE_MSB:sbcw_pkg::MODE_LSB] = mode_reg;
			end
			default: txData = 13'h0000; // Other register codes live elsewhere
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Writable fields update only on a complete write frame
	always_comb begin
		wdSel_next = wdSel_reg;
		period_next = period_reg;
		mode_next = mode_reg;
		softRst_next = 1'b0;
		if (writeStrobe) begin
			if (frameAddr == sbcw_pkg::ADDR_WD_STATUS) begin
				wdSel_next = rxWord[sbcw_pkg::WMS_BIT];
				period_next = framePeriod;
				// Status bits written here have no storage
				softRst_next = rxWord[sbcw_pkg::WOFF_BIT];
			end else if (frameAddr == sbcw_pkg::ADDR_MODE_CTRL) begin
				mode_next = frameMode;
			end
		end
		// Only code 11 powers the transceiver supply
		xcvrEn_next = (mode_next == sbcw_pkg::MODE_NORMAL_XON);
	end

	// Period code falls back to its default on every reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wdSel_reg <= sbcw_pkg::WMS_RST;
			period_reg <= sbcw_pkg::PERIOD_RST;
			mode_reg <= sbcw_pkg::MODE_RST;
			softRst_reg <= 1'b0;
			xcvrEn_reg <= 1'b0;
		end else begin
			wdSel_reg <= wdSel_next;
			period_reg <= period_next;
			mode_reg <= mode_next;
			softRst_reg <= softRst_next;
			xcvrEn_reg <= xcvrEn_next;
		end
	end

	assign operatingMode = mode_reg;
	assign xcvrSupplyEnable = xcvrEn_reg;
	assign watchdogModeSelect = wdSel_reg;
	assign watchdogPeriodCode = period_reg;
	// Soft reset is a one-cycle request; the reset unit turns it into sys_rst
	assign softResetReq = softRst_reg;

	////////////////////////////////////////////////////////////////
	// Watchdog mode resolution, one cycle behind the stored fields
	sbcw_wd_decode decoder (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.opMode(mode_reg),
		.wdModeSelect(wdSel_reg),
		.wdDisablePin(watchdogDisablePin),
		.periodCode(period_reg),
		.wdMode(watchdogMode),
		.wdPeriodMs(watchdogPeriodMs)
	);

	////////////////////////////////////////////////////////////////
	// Checks
	period_reset_a:
	assert property (@(posedge sys_clk) disable iff (1'b0)
		sys_rst |=> period_reg == sbcw_pkg::PERIOD_RST)
		else $error("period code not restored by reset");

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	period_write_a:
	assert property (writeStrobe && frameAddr == sbcw_pkg::ADDR_WD_STATUS
		|=> period_reg == $past(framePeriod))
		else $error("period write not taken");
	read_only_keep_a:
	assert property (frameDone && rxWord[sbcw_pkg::ACCESS_BIT]
		|=> $stable(period_reg) && $stable(mode_reg) && $stable(wdSel_reg) && !softResetReq)
		else $error("read-only frame changed contents");
	soft_reset_req_a:
	assert property (writeStrobe && frameAddr == sbcw_pkg::ADDR_WD_STATUS
		&& rxWord[sbcw_pkg::WOFF_BIT] |=> softResetReq ##1 !softResetReq)
		else $error("soft reset request missing or too long");
	mode_write_a:
	assert property (writeStrobe && frameAddr == sbcw_pkg::ADDR_MODE_CTRL
		|=> mode_reg == $past(frameMode))
		else $error("mode write not taken");
	mode_other_addr_a:
	assert property (writeStrobe && frameAddr != sbcw_pkg::ADDR_MODE_CTRL
		|=> $stable(mode_reg))
		else $error("mode changed by a frame for another register");
	xcvr_supply_a:
	assert property (xcvrSupplyEnable == (operatingMode == sbcw_pkg::MODE_NORMAL_XON))
		else $error("transceiver supply enable disagrees with mode");
	window_mode_a:
	assert property (!wdSel_reg && !watchdogDisablePin
		&& mode_reg == sbcw_pkg::MODE_NORMAL_XOFF && $stable(mode_reg)
		|=> watchdogMode == sbcw_pkg::SBCW_WD_WINDOW)
		else $error("watchdog not in window mode");
	standby_off_a:
	assert property (wdSel_reg && mode_reg == sbcw_pkg::MODE_STANDBY
		|=> watchdogMode == sbcw_pkg::SBCW_WD_OFF)
		else $error("watchdog not off in standby");
	disable_pin_a:
	assert property (watchdogDisablePin |=> watchdogMode == sbcw_pkg::SBCW_WD_OFF)
		else $error("disable pin did not stop the watchdog");
	status_readback_a:
	assert property (rxAddr == sbcw_pkg::ADDR_WD_STATUS
		|-> txData[sbcw_pkg::MAINUV_BIT] == mainSupplyUndervolt && txData[2:0] == 3'h0)
		else $error("status readback wrong");

	cover_period_write: cover property (writeStrobe ##1 period_reg == 3'h7);
	cover_soft_reset: cover property (softResetReq);
	cover_normal_on: cover property (xcvrSupplyEnable);
	cover_timeout_mode: cover property (watchdogMode == sbcw_pkg::SBCW_WD_TIMEOUT);
endmodule : sbcw_mode_regs

// >>> hw/sbcw_pkg.sv
package sbcw_pkg;
	// Frame layout of every control word
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_LEN = 5'h10;
	localparam logic [4:0] ADDR_LEN = 5'h03;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 13;
	localparam int ACCESS_BIT = 12;

	// Register select codes
	localparam logic [2:0] ADDR_WD_STATUS = 3'h0;
	localparam logic [2:0] ADDR_MODE_CTRL = 3'h1;

	// Watchdog-and-status field positions
	localparam int WMS_BIT = 11;
	localparam int PERIOD_MSB = 10;
	localparam int PERIOD_LSB = 8;
	localparam int WOFF_BIT = 7;
	localparam int MAINUV_BIT = 6;
	localparam int XCVRUV_BIT = 5;
	localparam int LOCAL_WAKE_INPUT_ONE_BIT = 4;
	localparam int LOCAL_WAKE_INPUT_TWO_BIT = 3;

	// Mode-control field positions
	localparam int MODE_MSB = 11;
	localparam int MODE_LSB = 10;

	// Reset values
	localparam logic WMS_RST = 1'h0;
	localparam logic [2:0] PERIOD_RST = 3'h4;
	localparam logic [1:0] MODE_RST = 2'h0;

	// Operating mode codes
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_SLEEP = 2'h1;
	localparam logic [1:0] MODE_NORMAL_XOFF = 2'h2;
	localparam logic [1:0] MODE_NORMAL_XON = 2'h3;

	// Nominal watchdog period in ms, indexed by period code
	localparam logic [12:0] PERIOD_MS [8] = '{13'h0008, 13'h0010, 13'h0020, 13'h0040,
		13'h0080, 13'h0100, 13'h0400, 13'h1000};

	typedef enum logic [1:0] {
		SBCW_WD_OFF,
		SBCW_WD_WINDOW,
		SBCW_WD_TIMEOUT
	} sbcw_wdmode_e;
endpackage : sbcw_pkg

// >>> hw/sbcw_spi_shift.sv
`timescale 1ns/1ps
module sbcw_spi_shift (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiDataIn,
	output logic spiDataOut,
	output logic spiDataOutEn,
	input wire logic [12:0] txData,
	output logic [2:0] rxAddr,
	output logic frameDone,
	output logic [15:0] rxWord
);
	logic sckPrev_reg, sckPrev_next;
	logic csPrev_reg, csPrev_next;
	logic [4:0] bitCnt_reg, bitCnt_next;
	logic [15:0] rxShift_reg, rxShift_next;
	logic [2:0] addr_reg, addr_next;
	logic dout_reg, dout_next;
	logic done_reg, done_next;
	logic sckRise, sckFall, csFall, csRise;
	logic [15:0] txWord;
	logic [3:0] txIdx;

	////////////////////////////////////////////////////////////////
	// Edge detection on the pin levels, taken as synchronous
	assign sckRise = spiClk && !sckPrev_reg;
	assign sckFall = !spiClk && sckPrev_reg;
	assign csFall = !spiCsN && csPrev_reg;
	assign csRise = spiCsN && !csPrev_reg;
	// Address bits are not known yet when they go out, so they return zero
	assign txWord = {3'h0, txData};
	assign txIdx = 4'(5'h0f - bitCnt_reg);

	// Sample on falling clock, shift out on rising clock
	always_comb begin
		sckPrev_next = spiClk;
		csPrev_next = spiCsN;
		bitCnt_next = bitCnt_reg;
		rxShift_next = rxShift_reg;
		addr_next = addr_reg;
		dout_next = dout_reg;
		done_next = 1'b0;
		if (csFall) begin
			bitCnt_next = 5'h00;
			rxShift_next = 16'h0000;
			dout_next = 1'b0;
		end else if (!spiCsN && sckFall) begin
			// Count past sixteen so a long frame is told apart from a full one
			if (bitCnt_reg < sbcw_pkg::FRAME_LEN) begin
				rxShift_next = {rxShift_reg[14:0], spiDataIn};
			end
			if (bitCnt_reg != 5'h1f) begin
				bitCnt_next = bitCnt_reg + 5'h01;
			end
			if (bitCnt_next == sbcw_pkg::ADDR_LEN) begin
				addr_next = {rxShift_reg[1:0], spiDataIn};
			end
		end else if (!spiCsN && sckRise) begin
			// Full-duplex readback of the addressed register
			dout_next = (bitCnt_reg < sbcw_pkg::FRAME_LEN) ? txWord[txIdx] : 1'b0;
		end
		// Short or long frames are dropped whole
		if (csRise && bitCnt_reg == sbcw_pkg::FRAME_LEN) begin
			done_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sckPrev_reg <= 1'b0;
			csPrev_reg <= 1'b1;
			bitCnt_reg <= 5'h00;
			rxShift_reg <= 16'h0000;
			addr_reg <= 3'h0;
			dout_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			sckPrev_reg <= sckPrev_next;
			csPrev_reg <= csPrev_next;
			bitCnt_reg <= bitCnt_next;
			rxShift_reg <= rxShift_next;
			addr_reg <= addr_next;
			dout_reg <= dout_next;
			done_reg <= done_next;
		end
	end

	assign spiDataOut = dout_reg;
	assign spiDataOutEn = !spiCsN;
	assign rxAddr = addr_reg;
	assign frameDone = done_reg;
	assign rxWord = rxShift_reg;

	////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	frame_length_a:
	assert property (frameDone |-> $past(bitCnt_reg) == sbcw_pkg::FRAME_LEN)
		else $error("frame accepted with wrong bit count");
	addr_bits_zero_a:
	assert property (csFall ##1 (!spiCsN && bitCnt_reg < sbcw_pkg::ADDR_LEN) [*3] |-> !spiDataOut)
		else $error("address slots not returned as zero");
	cover_full_frame: cover property (csFall ##[1:400] frameDone);
endmodule : sbcw_spi_shift

// >>> hw/sbcw_wd_decode.sv
`timescale 1ns/1ps
module sbcw_wd_decode (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [1:0] opMode,
	input wire logic wdModeSelect,
	input wire logic wdDisablePin,
	input wire logic [2:0] periodCode,
	output sbcw_pkg::sbcw_wdmode_e wdMode,
	output logic [12:0] wdPeriodMs
);
	sbcw_pkg::sbcw_wdmode_e mode_reg, mode_next;
	logic [12:0] ms_reg, ms_next;

	////////////////////////////////////////////////////////////////
	// Pin override first, then mode select against operating mode
	always_comb begin
		ms_next = sbcw_pkg::PERIOD_MS[periodCode];
		mode_next = sbcw_pkg::SBCW_WD_OFF;
		if (!wdDisablePin) begin
			unique case (opMode)
				sbcw_pkg::MODE_STANDBY: mode_next = wdModeSelect ?
					sbcw_pkg::SBCW_WD_OFF : sbcw_pkg::SBCW_WD_TIMEOUT;
				sbcw_pkg::MODE_SLEEP: mode_next = sbcw_pkg::SBCW_WD_OFF;
				sbcw_pkg::MODE_NORMAL_XOFF,
				sbcw_pkg::MODE_NORMAL_XON: mode_next = wdModeSelect ?
					sbcw_pkg::SBCW_WD_TIMEOUT : sbcw_pkg::SBCW_WD_WINDOW;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mode_reg <= sbcw_pkg::SBCW_WD_OFF;
			ms_reg <= 13'h0000;
		end else begin
			mode_reg <= mode_next;
			ms_reg <= ms_next;
		end
	end

	assign wdMode = mode_reg;
	assign wdPeriodMs = ms_reg;
endmodule : sbcw_wd_decode

// >>> test/sbcw_spi_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Microcontroller side of the serial link, mode: sample falling, shift rising
module sbcw_spi_master (
	input wire logic sys_clk,
	output logic spiClk,
	output logic spiCsN,
	output logic spiDataIn,
	input wire logic spiDataOut,
	input wire logic spiDataOutEn
);
	logic sdoLast;
	logic sdoLine;

	// A released data line shows the inverse of its last level, so no stale value passes
	assign sdoLine = spiDataOutEn ? spiDataOut : ~sdoLast;
	initial sdoLast = 1'b0;
	always @(posedge sys_clk) begin
		sdoLast <= sdoLine;
	end

	// Idle levels: select high, clock low
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiDataIn = 1'b0;
	end

	// One frame, MSB first; each clock level lasts four cycles, well above the minimum
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge sys_clk) spiCsN = 1'b0;
		repeat (2) @(negedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			spiDataIn = (i < 16) ? tx[15 - i] : 1'b0;
			spiClk = 1'b1;
			repeat (4) @(negedge sys_clk);
			if (i < 16) rx[15 - i] = sdoLine;
			spiClk = 1'b0;
			repeat (4) @(negedge sys_clk);
		end
		spiCsN = 1'b1;
		// Data line no longer meaningful once deselected
		spiDataIn = ~spiDataIn;
		repeat (4) @(negedge sys_clk);
	endtask : xfer
endmodule : sbcw_spi_master

// >>> test/sbc_watchdog_mode_registers_tb_top.sv
`timescale 1ns/1ps
module sbc_watchdog_mode_registers_tb_top;
	logic sys_clk;
	logic sys_rst;
	logic spiClk;
	logic spiCsN;
	logic spiDataIn;
	logic spiDataOut;
	logic spiDataOutEn;
	logic wdPin;
	logic mainUv;
	logic xcvrUv;
	logic wakeOne;
	logic wakeTwo;
	logic [1:0] operatingMode;
	logic xcvrSupplyEnable;
	logic watchdogModeSelect;
	logic [2:0] watchdogPeriodCode;
	logic [12:0] watchdogPeriodMs;
	sbcw_pkg::sbcw_wdmode_e watchdogMode;
	logic softResetReq;
	int fails;
	int num_checks;
	int pulses;
	logic [15:0] rx;
	logic sel;
	logic [2:0] per;
	logic [1:0] mode;

	////////////////////////////////////////////////////////////////////////////
	sbcw_mode_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spiClk(spiClk),
		.spiCsN(spiCsN), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
		.spiDataOutEn(spiDataOutEn), .watchdogDisablePin(wdPin),
		.mainSupplyUndervolt(mainUv), .xcvrSupplyUndervolt(xcvrUv),
		.wakeInputOneLevel(wakeOne), .wakeInputTwoLevel(wakeTwo),
		.operatingMode(operatingMode), .xcvrSupplyEnable(xcvrSupplyEnable),
		.watchdogModeSelect(watchdogModeSelect), .watchdogPeriodCode(watchdogPeriodCode),
		.watchdogPeriodMs(watchdogPeriodMs), .watchdogMode(watchdogMode),
		.softResetReq(softResetReq));
	sbcw_spi_master master (.sys_clk(sys_clk), .spiClk(spiClk), .spiCsN(spiCsN),
		.spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn));

	////////////////////////////////////////////////////////////////////////////
	// Clock and a count of soft reset pulses
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (softResetReq === 1'b1) pulses++;
	end

	function automatic bit cnt(input bit m);
		num_checks++;
		return m;
	endfunction : cnt

	task automatic bad(input string msg);
		fails++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask : bad

	task automatic wrap_up();
		if (fails == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up

	// Expected readback of the watchdog-and-status register from the bench's own state
	function automatic logic [15:0] expWd();
		return {4'h0, sel, per, wdPin, mainUv, xcvrUv, wakeOne, wakeTwo, 3'h0};
	endfunction : expWd

	function automatic sbcw_pkg::sbcw_wdmode_e expMode();
		if (wdPin || mode == 2'h1) return sbcw_pkg::SBCW_WD_OFF;
		if (mode == 2'h0) return sel ? sbcw_pkg::SBCW_WD_OFF : sbcw_pkg::SBCW_WD_TIMEOUT;
		return sel ? sbcw_pkg::SBCW_WD_TIMEOUT : sbcw_pkg::SBCW_WD_WINDOW;
	endfunction : expMode

	// Period in ms, doubling except the two long top codes
	function automatic logic [12:0] expMs(input logic [2:0] k);
		if (k < 3'h6) return 13'h0008 << k;
		return (k == 3'h6) ? 13'h0400 : 13'h1000;
	endfunction : expMs

	task automatic frame(input logic [2:0] a, input logic ro, input logic [11:0] d, input int n);
		master.xfer({a, ro, d}, n, rx);
	endtask : frame

	task automatic check_state(input string msg);
		if (cnt(watchdogPeriodCode !== per)) bad({msg, " period code"});
		if (cnt(watchdogPeriodMs !== expMs(per))) bad({msg, " period ms"});
		if (cnt(watchdogModeSelect !== sel)) bad({msg, " select"});
		if (cnt(operatingMode !== mode)) bad({msg, " mode"});
		if (cnt(xcvrSupplyEnable !== (mode == 2'h3))) bad({msg, " xcvr enable"});
		if (cnt(watchdogMode !== expMode())) bad({msg, " wd mode"});
	endtask : check_state

	////////////////////////////////////////////////////////////////////////////
	// Reset values through read-only frames
	task automatic t_reset();
		{wdPin, mainUv, xcvrUv, wakeOne, wakeTwo} = 5'h15;
		frame(sbcw_pkg::ADDR_WD_STATUS, 1'b1, 12'hfff, 16);
		if (cnt(rx !== expWd())) bad("reset readback");
		frame(sbcw_pkg::ADDR_MODE_CTRL, 1'b1, 12'hfff, 16);
		if (cnt(rx !== 16'h0000)) bad("mode reset readback");
		check_state("after reset");
	endtask : t_reset

	// Every period code, with live status and read-only protection
	task automatic t_period();
		for (int k = 0; k < 8; k++) begin
			per = k[2:0];
			sel = k[0];
			{wdPin, mainUv, xcvrUv, wakeOne, wakeTwo} = 5'(k * 5 + 3);
			frame(sbcw_pkg::ADDR_WD_STATUS, 1'b0, {sel, per, 8'h7f}, 16);
			check_state("period write");
			frame(sbcw_pkg::ADDR_WD_STATUS, 1'b1, {~sel, ~per, 8'hff}, 16);
			if (cnt(rx !== expWd())) bad("status readback");
			check_state("read only");
		end
	endtask : t_period

	// All mode codes against both select values and the disable pin
	task automatic t_mode();
		for (int s = 0; s < 2; s++) begin
			sel = s[0];
			wdPin = 1'b0;
			frame(sbcw_pkg::ADDR_WD_STATUS, 1'b0, {sel, per, 8'h00}, 16);
			for (int m = 0; m < 4; m++) begin
				mode = m[1:0];
				frame(sbcw_pkg::ADDR_MODE_CTRL, 1'b0, {mode, 10'h3ff}, 16);
				check_state("mode pin low");
				frame(sbcw_pkg::ADDR_MODE_CTRL, 1'b1, 12'h000, 16);
				if (cnt(rx !== {4'h0, mode, 10'h000})) bad("mode readback");
				@(negedge sys_clk) wdPin = 1'b1;
				repeat (3) @(negedge sys_clk);
				check_state("mode pin high");
				wdPin = 1'b0;
				repeat (3) @(negedge sys_clk);
			end
		end
	endtask : t_mode

	// Soft reset only from a write of the watchdog register
	task automatic t_soft();
		pulses = 0;
		frame(sbcw_pkg::ADDR_WD_STATUS, 1'b0, {sel, per, 8'h80}, 16);
		if (cnt(pulses != 1)) bad("soft reset pulse");
		frame(sbcw_pkg::ADDR_WD_STATUS, 1'b1, {sel, per, 8'h80}, 16);
		frame(sbcw_pkg::ADDR_MODE_CTRL, 1'b0, {mode, 10'h080}, 16);
		if (cnt(pulses != 1)) bad("stray soft reset");
		check_state("after soft reset");
	endtask : t_soft

	// Short frames and unknown addresses change nothing
	task automatic t_refuse();
		frame(sbcw_pkg::ADDR_WD_STATUS, 1'b0, {~sel, ~per, 8'h80}, 15);
		frame(sbcw_pkg::ADDR_MODE_CTRL, 1'b0, {~mode, 10'h000}, 17);
		frame(3'h5, 1'b0, 12'hfff, 16);
		if (cnt(rx !== 16'h0000)) bad("unknown address readback");
		if (cnt(pulses != 1)) bad("refused frame reset");
		check_state("refused frames");
	endtask : t_refuse

	////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset held twelve cycles, then each scenario
	initial begin
		fails = 0;
		num_checks = 0;
		pulses = 0;
		sys_rst = 1'b1;
		{wdPin, mainUv, xcvrUv, wakeOne, wakeTwo} = 5'h00;
		sel = sbcw_pkg::WMS_RST;
		per = sbcw_pkg::PERIOD_RST;
		mode = sbcw_pkg::MODE_RST;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset();
		t_period();
		t_mode();
		t_soft();
		t_refuse();
		wrap_up();
	end

	// Watchdog: the run needs about 5700 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		fails++;
		wrap_up();
	end
endmodule : sbc_watchdog_mode_registers_tb_top
